// *** src/tev_ctrl_status.sv ***
/*
  Transmit event FIFO control and status: control word, status word, user
  address, pointer bookkeeping, overflow capture and interrupt request.
  Assumes the host link delivers one-cycle register requests on clk_in and the
  transmit engine raises a one-cycle push per finished transmission.
*/
module tev_ctrl_status
  import tev_pkg::*;
(
  input  wire logic         clk_in,          // 125 MHz clock.
  input  wire logic         reset_n_in,      // Synchronous reset, active low.
  input  wire tev_reg_req_t reg_req_in,      // One-cycle register request.
  input  wire logic         config_mode_in,  // High while unit is in configuration.
  input  wire logic         event_push_in,   // Engine finished one transmission.
  input  wire logic [31:0]  timebase_in,     // Free-running time base.
  output logic [31:0]       rdata_out,       // Read data, one cycle after rd.
  output logic              rvalid_out,      // Marks rdata_out.
  output logic              irq_out,         // Event FIFO interrupt request.
  output logic              stamp_en_out,    // Stamping enabled for the engine.
  output logic [31:0]       stamp_out,       // Stamp of the last accepted object.
  output logic              push_ok_out,     // Push of the previous cycle was stored.
  output logic              reset_busy_out   // FIFO reset bit state.
);

  ////////////////////////////////////////////////////////////////////////////
  // State.
  tev_ctrl_t  ctrl_q;
  logic       rst_q;
  logic       ovf_q;
  logic [4:0] head_q;
  logic [4:0] tail_q;
  logic [5:0] count_q;
  logic [31:0] rdata_q;
  logic        rvalid_q;
  logic        irq_q;
  logic [31:0] stamp_q;
  logic        push_ok_q;

  logic [5:0]  depth;
  logic        wr_ctrl;
  logic        wr_status;
  logic        push_ok;
  logic        pop_ok;
  logic        full;
  logic        half;
  logic        not_empty;
  tev_flags_t  flags;
  logic [31:0] obj_bytes;
  logic [31:0] user_addr;

  assign depth     = {1'b0, ctrl_q.depth_field} + 6'h01;
  assign wr_ctrl   = reg_req_in.wr && tev_hit(reg_req_in, TEV_CTRL_ADDR);
  assign wr_status = reg_req_in.wr && tev_hit(reg_req_in, TEV_STATUS_ADDR);
  // Objects are stored or removed only while the FIFO is out of reset.
  assign push_ok   = event_push_in && !rst_q && !full;
  assign pop_ok    = wr_ctrl && reg_req_in.wdata[TEV_TAIL_INCREMENT_BIT_BIT] && !rst_q && not_empty;
  assign flags     = '{ovf: ovf_q, full: full, half: half, not_empty: not_empty};
  assign obj_bytes = ctrl_q.stamp_en ? TEV_OBJ_STAMP : TEV_OBJ_PLAIN;
  assign user_addr = TEV_RAM_BASE + 32'(tail_q) * obj_bytes;

  tev_level_flags u_flags (
    .count_in      (count_q),
    .depth_in      (depth),
    .full_out      (full),
    .half_out      (half),
    .not_empty_out (not_empty)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control word.
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      ctrl_q <= '{depth_field: TEV_DEPTH_RST, stamp_en: 1'b0, irq_en: 4'h0};
    end else if (wr_ctrl) begin
      ctrl_q.irq_en <= reg_req_in.wdata[TEV_IE_MSB:0];
      if (config_mode_in) begin
        ctrl_q.depth_field <= reg_req_in.wdata[TEV_DEPTH_MSB:TEV_DEPTH_LSB];
        ctrl_q.stamp_en    <= reg_req_in.wdata[TEV_TSEN_BIT];
      end
    end
  end

  // A written reset in normal mode lasts exactly one cycle: the pointers are
  // cleared in that cycle and the bit reads back zero from the next one.
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      rst_q <= TEV_RST_RST;
    end else if (config_mode_in) begin
      rst_q <= 1'b1;
    end else if (wr_ctrl && reg_req_in.wdata[TEV_RST_BIT]) begin
      rst_q <= 1'b1;
    end else begin
      rst_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointers and occupancy.
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || rst_q) begin
      head_q  <= 5'h00;
      tail_q  <= 5'h00;
      count_q <= 6'h00;
    end else begin
      if (push_ok) begin
        head_q <= (6'(head_q) == depth - 6'h01) ? 5'h00 : head_q + 5'h01;
      end
      if (pop_ok) begin
        tail_q <= (6'(tail_q) == depth - 6'h01) ? 5'h00 : tail_q + 5'h01;
      end
      if (push_ok && !pop_ok) begin
        count_q <= count_q + 6'h01;
      end else if (pop_ok && !push_ok) begin
        count_q <= count_q - 6'h01;
      end
    end
  end

  // A loss in the same cycle as a status write clear keeps the flag set; a FIFO reset clears it.
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || rst_q) begin
      ovf_q <= 1'b0;
    end else if (event_push_in && full) begin
      ovf_q <= 1'b1;
    end else if (wr_status && !reg_req_in.wdata[TEV_OVF_BIT]) begin
      ovf_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      stamp_q   <= 32'h0000_0000;
      push_ok_q <= 1'b0;
    end else begin
      push_ok_q <= push_ok;
      if (push_ok) begin
        stamp_q <= ctrl_q.stamp_en ? timebase_in : 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path and interrupt.
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      rdata_q  <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_req_in.rd;
      if (reg_req_in.rd) begin
        if (tev_hit(reg_req_in, TEV_CTRL_ADDR)) begin
          rdata_q <= {3'h0, ctrl_q.depth_field, 13'h0000, rst_q, 4'h0,
                      ctrl_q.stamp_en, 1'b0, ctrl_q.irq_en};
        end else if (tev_hit(reg_req_in, TEV_STATUS_ADDR)) begin
          rdata_q <= {28'h000_0000, flags};
        end else if (tev_hit(reg_req_in, TEV_UADDR_ADDR)) begin
          rdata_q <= user_addr;
        end else begin
          rdata_q <= 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(flags & ctrl_q.irq_en);
    end
  end

  assign rdata_out      = rdata_q;
  assign rvalid_out     = rvalid_q;
  assign irq_out        = irq_q;
  assign stamp_en_out   = ctrl_q.stamp_en;
  assign stamp_out      = stamp_q;
  assign push_ok_out    = push_ok_q;
  assign reset_busy_out = rst_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence s_tail_step;
    pop_ok && !push_ok ##1 1'b1;
  endsequence

  sequence s_normal_reset;
    !config_mode_in && rst_q && !wr_ctrl;
  endsequence

  depth_bound_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    count_q <= depth)
    else $error("event count above configured depth");

  reset_release_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_normal_reset |=> !rst_q && count_q == 6'h00)
    else $error("fifo reset did not complete in one cycle");

  // The pointers clear on the edge after the bit rises, so emptiness is checked a cycle later.
  config_hold_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    config_mode_in |=> rst_q ##1 count_q == 6'h00)
    else $error("fifo reset bit not held in configuration");

  tail_step_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_tail_step |-> count_q == $past(count_q) - 6'h01)
    else $error("tail increment did not remove one object");

  stamp_off_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    push_ok && !ctrl_q.stamp_en |=> stamp_q == 32'h0000_0000)
    else $error("stamp present while stamping disabled");

  config_lock_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !config_mode_in |=> ctrl_q.depth_field == $past(ctrl_q.depth_field) &&
    ctrl_q.stamp_en == $past(ctrl_q.stamp_en))
    else $error("locked field changed outside configuration");

  overflow_set_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    event_push_in && full && !rst_q |=> ovf_q [*1] ##1 (ovf_q || $past(wr_status)
    || $past(rst_q)))
    else $error("overflow not captured or lost early");

  irq_gate_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ##1 irq_out == |($past(flags) & $past(ctrl_q.irq_en)))
    else $error("interrupt request does not follow enabled flags");

  status_upper_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    reg_req_in.rd && tev_hit(reg_req_in, TEV_STATUS_ADDR) |=>
    rvalid_out && rdata_out[31:4] == 28'h000_0000)
    else $error("status upper bits not zero");

endmodule

// *** src/tev_level_flags.sv ***
/*
  Occupancy flags of the event FIFO, derived from count and configured depth.
  Assumes count never exceeds depth; the instantiating module registers results.
*/
module tev_level_flags
  import tev_pkg::*;
(
  input  wire logic [5:0] count_in,      // Objects currently held.
  input  wire logic [5:0] depth_in,      // Configured depth, 1 to 32.
  output logic            full_out,      // Every entry occupied.
  output logic            half_out,      // At least half of the depth occupied.
  output logic            not_empty_out  // At least one object held.
);

  // Doubling the count avoids a rounding choice for odd depths.
  assign full_out      = (count_in == depth_in);
  assign half_out      = ({count_in, 1'b0} >= {1'b0, depth_in});
  assign not_empty_out = (count_in != 6'h00);

endmodule

// *** src/tev_pkg.sv ***
/*
  Shared constants and types of the transmit event FIFO control and status block.
  Assumes a single 125 MHz clock domain and a register port that is already
  decoded from the serial host link into word-wide requests.
*/
package tev_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register word addresses on the internal register port.
  localparam logic [11:0] TEV_CTRL_ADDR   = 12'h040;
  localparam logic [11:0] TEV_STATUS_ADDR = 12'h044;
  localparam logic [11:0] TEV_UADDR_ADDR  = 12'h048;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions in the control word.
  localparam int TEV_DEPTH_LSB = 24;
  localparam int TEV_DEPTH_MSB = 28;
  localparam int TEV_RST_BIT   = 10;
  localparam int TEV_TAIL_INCREMENT_BIT_BIT  = 8;
  localparam int TEV_TSEN_BIT  = 5;
  localparam int TEV_IE_MSB    = 3;

  // Field positions in the status word; enables use the same positions.
  localparam int TEV_OVF_BIT   = 3;
  localparam int TEV_FULL_BIT  = 2;
  localparam int TEV_HALF_BIT  = 1;
  localparam int TEV_NE_BIT    = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and sizes.
  localparam logic [4:0]  TEV_DEPTH_RST = 5'h00;
  localparam logic        TEV_RST_RST   = 1'b1;
  localparam logic [5:0]  TEV_MAX_DEPTH = 6'h20;
  // Base of the event area in message RAM; the value is arbitrary.
  localparam logic [31:0] TEV_RAM_BASE  = 32'h0000_0400;
  localparam logic [31:0] TEV_OBJ_PLAIN = 32'h0000_0008;
  localparam logic [31:0] TEV_OBJ_STAMP = 32'h0000_000C;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers.
  typedef struct packed {
    logic [4:0] depth_field;
    logic       stamp_en;
    logic [3:0] irq_en;
  } tev_ctrl_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } tev_reg_req_t;

  typedef struct packed {
    logic ovf;
    logic full;
    logic half;
    logic not_empty;
  } tev_flags_t;

  function automatic logic tev_hit(input tev_reg_req_t req, input logic [11:0] addr);
    tev_hit = (req.addr == addr);
  endfunction

endpackage

// *** testbench/testbench.sv ***
/*
  Self-checking bench for the event FIFO control and status block.
  Assumes the host model drives the register port; the bench plays the engine.
*/
module testbench
  import tev_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic         clk_in, reset_n_in, config_mode_in, event_push_in;
  logic [31:0]  timebase_in, rdata, stamp;
  logic         rvalid, irq, stamp_en, push_ok, busy, ok;
  tev_reg_req_t req;
  int           err_count, samples_checked, cycles;

  tev_ctrl_status i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .reg_req_in(req),
    .config_mode_in(config_mode_in), .event_push_in(event_push_in),
    .timebase_in(timebase_in), .rdata_out(rdata), .rvalid_out(rvalid), .irq_out(irq),
    .stamp_en_out(stamp_en), .stamp_out(stamp), .push_ok_out(push_ok),
    .reset_busy_out(busy));
  tev_host_model i_host (.clk_in(clk_in), .rdata_in(rdata), .rvalid_in(rvalid),
    .req_out(req));

  ////////////////////////////////////////////////////////////////////////////
  always #4 clk_in = ~clk_in;

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // A hang costs a mismatch; the whole sequence needs well under a thousand cycles.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      test_done();
    end
  end

  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string n);
    logic [31:0] v;
    i_host.rd(a, v);
    check(n, v, e);
  endtask

  task automatic push(input logic ok_exp, input logic [31:0] tb);
    @(posedge clk_in);
    event_push_in <= 1'b1;
    timebase_in   <= tb;
    @(posedge clk_in);
    event_push_in <= 1'b0;
    #1;
    check("push stored", push_ok, ok_exp);
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk_in);
    #1;
    check("irq", irq, e);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] exp_st [5] = '{32'h1, 32'h3, 32'h3, 32'h7, 32'hF};
    clk_in = 1'b0;
    reset_n_in = 1'b0;
    config_mode_in = 1'b1;
    event_push_in = 1'b0;
    timebase_in = 32'h0000_5A00;
    repeat (10) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rdc(TEV_CTRL_ADDR, 32'h0000_0400, "ctrl reset");
    check("busy in config", busy, 1'b1);
    rdc(TEV_STATUS_ADDR, 32'h0, "status reset");
    rdc(12'h07C, 32'h0, "unmapped");
    i_host.wr(TEV_CTRL_ADDR, 32'h0300_002F);
    rdc(TEV_CTRL_ADDR, 32'h0300_042F, "ctrl config");
    @(posedge clk_in);
    config_mode_in <= 1'b0;
    i_host.wait_reset_done(ok);
    check("reset clears", ok, 1'b1);
    check("busy clear", busy, 1'b0);
    i_host.wr(TEV_CTRL_ADDR, 32'h1F00_000F);
    rdc(TEV_CTRL_ADDR, 32'h0300_002F, "ctrl locked");
    check("stamp enable", stamp_en, 1'b1);
    for (int i = 0; i < 5; i++) begin
      push(i < 4, 32'h0000_5A01 + 32'(i));
      rdc(TEV_STATUS_ADDR, exp_st[i], "status fill");
    end
    check("stamp", stamp, 32'h0000_5A04);
    irq_is(1'b1);
    rdc(TEV_UADDR_ADDR, 32'h0000_0400, "uaddr");
    i_host.wr(TEV_CTRL_ADDR, 32'h0000_012F);
    rdc(TEV_UADDR_ADDR, 32'h0000_040C, "uaddr inc");
    rdc(TEV_STATUS_ADDR, 32'hB, "ovf sticks");
    i_host.wr(TEV_STATUS_ADDR, 32'h0);
    rdc(TEV_STATUS_ADDR, 32'h3, "ovf cleared");
    for (int k = 0; k < 4; k++) begin
      i_host.wr(TEV_CTRL_ADDR, 32'(1 << k));
      irq_is(k < 2);
    end
    i_host.wr(TEV_CTRL_ADDR, 32'h0000_0400);
    i_host.wait_reset_done(ok);
    check("fifo reset done", ok, 1'b1);
    rdc(TEV_STATUS_ADDR, 32'h0, "fifo reset");
    @(posedge clk_in);
    config_mode_in <= 1'b1;
    i_host.wr(TEV_CTRL_ADDR, 32'h0000_0001);
    @(posedge clk_in);
    config_mode_in <= 1'b0;
    i_host.wait_reset_done(ok);
    push(1'b1, 32'h0000_6B00);
    check("no stamp", stamp, 32'h0);
    rdc(TEV_STATUS_ADDR, 32'h7, "depth one");
    push(1'b0, 32'h0000_6B01);
    rdc(TEV_STATUS_ADDR, 32'hF, "ovf depth one");
    i_host.wr(TEV_CTRL_ADDR, 32'h0000_0101);
    rdc(TEV_UADDR_ADDR, 32'h0000_0400, "uaddr wrap");
    rdc(TEV_STATUS_ADDR, 32'h8, "pop depth one");
    @(posedge clk_in);
    config_mode_in <= 1'b1;
    i_host.wr(TEV_CTRL_ADDR, 32'h0100_0000);
    @(posedge clk_in);
    config_mode_in <= 1'b0;
    i_host.wait_reset_done(ok);
    check("depth two ready", ok, 1'b1);
    push(1'b1, 32'h0000_6B02);
    i_host.wr(TEV_CTRL_ADDR, 32'h0000_0100);
    rdc(TEV_UADDR_ADDR, 32'h0000_0408, "uaddr plain");
    test_done();
  end
endmodule

// *** testbench/tev_host_model.sv ***
/*
  Host model: issues whole-word reads and writes on the register port.
  Assumes the block answers a read with rvalid_out a cycle after the request.
*/
module tev_host_model
  import tev_pkg::*;
(
  input  wire logic        clk_in,     // Block clock.
  input  wire logic [31:0] rdata_in,   // Read data from the block.
  input  wire logic        rvalid_in,  // Marks read data.
  output tev_reg_req_t     req_out     // One-cycle register request.
);
  timeunit 1ns;
  timeprecision 1ps;

  initial req_out = '0;

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    req_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in);
    req_out <= '0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    int n;
    @(posedge clk_in);
    req_out <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge clk_in);
    req_out <= '0;
    n = 0;
    #1;
    while (rvalid_in !== 1'b1 && n < 4) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    d = (rvalid_in === 1'b1) ? rdata_in : 32'hXXXX_XXXX;
  endtask

  // Nothing else may touch the FIFO before the reset bit reads back clear.
  task automatic wait_reset_done(output logic ok);
    logic [31:0] v;
    ok = 1'b0;
    repeat (8) begin
      rd(TEV_CTRL_ADDR, v);
      if (v[TEV_RST_BIT] === 1'b0) begin
        ok = 1'b1;
        break;
      end
    end
  endtask
endmodule
